// *** inc/tws_defs.vh ***
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// ---------------------------------------------
// bit counter marks
// ---------------------------------------------
`define TWS_CNT_ZERO     4'h0
`define TWS_CNT_LAST_BIT 4'h7
`define TWS_CNT_ACK_SLOT 4'h8
`define TWS_CNT_ACK_DONE 4'h9

// ---------------------------------------------
// bus mode slave states
// ---------------------------------------------
`define TWS_ST_IDLE 2'h0
`define TWS_ST_ADDR 2'h1
`define TWS_ST_DATA 2'h2
`define TWS_ST_OFF  2'h3

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define TWS_SHIFT_RST 8'hFF
`define TWS_SO_RST    1'h1

`endif

// *** verilog/tws_port.v ***
// Functional notes
// - enable after data write starts nothing
// - stop after eight bits, set done flag
// - shift register captures real data line
// - address match flag shows shift equals address; bus mode compares bits 7:1 only
// - bus pins open drain, low or released
// - slave detects start, data, stop in hardware
// - wakeup irq on address match and stop
// - slave holds clock low while preparing data
// - data fall with clock high is start
// - data rise with clock high is stop
// - seven bits after start compared as address
// - only matched slave talks until start/stop
// - bit after address selects direction
// - receiver acknowledges every eight bit byte
// - transmitter waits for ack, stops on none
// - msb first, out on fall, in on rise
// - bus mode with wakeup set: irq only on address match and on stop
`include "tws_defs.vh"

module tws_port (
   // clock and reset
   input  wire       sys_clk,
   input  wire       reset,
   // configuration
   input  wire       channel_enable,
   input  wire       bus_mode,
   input  wire       wakeup_select,
   input  wire [7:0] slave_address_register,
   // shift register access
   input  wire       shift_wr,
   input  wire [7:0] shift_wdata,
   output wire [7:0] serial_shift_register,
   // wait and flag control
   input  wire       wait_release,
   input  wire       irq_clear,
   // status
   output wire       transfer_done_irq_flag,
   output wire       address_match_flag,
   output wire       slave_selected,
   output wire       direction_tx,
   output wire       nack_seen,
   output wire       start_seen,
   output wire       stop_seen,
   output wire       transfer_busy,
   output wire       clock_line_level,
   // clock line pin
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe,
   // data line pin
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe
);

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   reg [7:0] sh_q;
   reg [3:0] cnt_q;
   reg [1:0] st_q;
   reg       armed_q;
   reg       so_q;
   reg       dir_q;
   reg       nack_q;
   reg       was_addr_q;
   reg       stretch_q;
   reg       done_q;
   reg       match_q;
   reg       start_q;
   reg       stop_q;

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   // two flops per pin, then a third stage for edge finding
   // reset to the released level so no false edge follows reset
   wire [1:0] pin_raw = {sda_in, scl_in};
   reg  [1:0] pin_m_q;
   reg  [1:0] pin_s_q;
   reg  [1:0] pin_p_q;
   genvar     gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         always @(posedge sys_clk) begin
            if (reset) begin
               pin_m_q[gi] <= 1'b1;
               pin_s_q[gi] <= 1'b1;
               pin_p_q[gi] <= 1'b1;
            end else begin
               pin_m_q[gi] <= pin_raw[gi];
               pin_s_q[gi] <= pin_m_q[gi];
               pin_p_q[gi] <= pin_s_q[gi];
            end
         end
      end
   endgenerate

   // bit 0 is the clock line, bit 1 the data line
   // only the second stage onward is read by logic
   wire scl_s_q = pin_s_q[0];
   wire scl_p_q = pin_p_q[0];
   wire sda_s_q = pin_s_q[1];
   wire sda_p_q = pin_p_q[1];

   // ---------------------------------------------
   // edge and condition detect
   // ---------------------------------------------
   wire scl_rise = scl_s_q & ~scl_p_q;
   wire scl_fall = ~scl_s_q & scl_p_q;
   // conditions from successive samples, clock steady high
   wire cond_ok  = channel_enable & bus_mode & scl_s_q & scl_p_q;
   wire start_det = cond_ok & sda_p_q & ~sda_s_q;
   wire stop_det  = cond_ok & ~sda_p_q & sda_s_q;
   // byte as it stands once the eighth bit is in
   wire [7:0] new_byte = {sh_q[6:0], sda_s_q};
   wire       addr_hit = (new_byte[7:1] == slave_address_register[7:1]);

   // sequencer state decode: address and data phases are live
   reg in_xfer;
   reg data_phase;
   always @* begin
      in_xfer    = 1'b0;
      data_phase = 1'b0;
      case (st_q)
         `TWS_ST_ADDR: begin
            in_xfer = 1'b1;
         end
         `TWS_ST_DATA: begin
            in_xfer    = 1'b1;
            data_phase = 1'b1;
         end
         default: begin
            in_xfer    = 1'b0;
            data_phase = 1'b0;
         end
      endcase
   end

   // our bits go out only when selected, reading, and acked
   wire       tx_data  = data_phase & dir_q & ~nack_q;

   // ---------------------------------------------
   // event that sets the done flag
   // ---------------------------------------------
   reg done_set;
   always @* begin
      done_set = 1'b0;
      if (channel_enable & ~bus_mode) begin
         done_set = armed_q & scl_rise & (cnt_q == `TWS_CNT_LAST_BIT);
      end else if (channel_enable) begin
         if (stop_det)
            done_set = wakeup_select;
         else if (in_xfer & scl_rise & (cnt_q == `TWS_CNT_LAST_BIT)) begin
            if (wakeup_select)
               done_set = (st_q == `TWS_ST_ADDR) & addr_hit;
            else
               done_set = 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // done flag, set wins over clear
   // ---------------------------------------------
   always @(posedge sys_clk) begin
      if (reset)
         done_q <= 1'b0;
      else if (done_set)
         done_q <= 1'b1;
      else if (irq_clear)
         done_q <= 1'b0;
   end

   // ---------------------------------------------
   // shift engine and bus slave sequencing
   // ---------------------------------------------
   // data line only ever changes while the clock is low,
   // so our own drive can never look like a start or stop;
   // a start seen mid-byte simply restarts the address phase
   always @(posedge sys_clk) begin
      if (reset) begin
         sh_q       <= `TWS_SHIFT_RST;
         cnt_q      <= `TWS_CNT_ZERO;
         st_q       <= `TWS_ST_IDLE;
         armed_q    <= 1'b0;
         so_q       <= `TWS_SO_RST;
         dir_q      <= 1'b0;
         nack_q     <= 1'b0;
         was_addr_q <= 1'b0;
         stretch_q  <= 1'b0;
         match_q    <= 1'b0;
         start_q    <= 1'b0;
         stop_q     <= 1'b0;
      end else begin
         start_q <= start_det;
         stop_q  <= stop_det;
         if (~channel_enable) begin
            // stopped: writes ignored, nothing armed
            cnt_q     <= `TWS_CNT_ZERO;
            st_q      <= `TWS_ST_IDLE;
            armed_q   <= 1'b0;
            so_q      <= `TWS_SO_RST;
            stretch_q <= 1'b0;
            nack_q    <= 1'b0;
            match_q   <= 1'b0;
         end else if (~bus_mode) begin
            // two-wire mode: match compares whole byte
            match_q <= (sh_q == slave_address_register);
            if (shift_wr & ~armed_q) begin
               sh_q    <= shift_wdata; // all ones keeps line released
               armed_q <= 1'b1;
               cnt_q   <= `TWS_CNT_ZERO;
            end else if (armed_q & scl_fall) begin
               so_q <= sh_q[7]; // msb out on falling edge
            end else if (armed_q & scl_rise) begin
               sh_q  <= new_byte; // real line level read back
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == `TWS_CNT_LAST_BIT)
                  armed_q <= 1'b0; // halt after eight bits
            end
         end else if (start_det) begin
            // new start: any partner choice is dropped
            st_q       <= `TWS_ST_ADDR;
            cnt_q      <= `TWS_CNT_ZERO;
            so_q       <= 1'b1;
            stretch_q  <= 1'b0;
            nack_q     <= 1'b0;
            dir_q      <= 1'b0;
            was_addr_q <= 1'b0;
         end else if (stop_det) begin
            st_q      <= `TWS_ST_IDLE;
            cnt_q     <= `TWS_CNT_ZERO;
            so_q      <= 1'b1;
            stretch_q <= 1'b0;
         end else if (in_xfer) begin
            // a load or a release ends the wait; a load also
            // puts the first bit out while the clock is still held
            if (shift_wr & stretch_q) begin
               // new byte loaded while clock held: first bit out now
               sh_q      <= shift_wdata;
               so_q      <= dir_q ? shift_wdata[7] : 1'b1;
               stretch_q <= 1'b0;
            end else if (wait_release & stretch_q) begin
               stretch_q <= 1'b0;
            end else if (scl_rise) begin
               if (cnt_q < `TWS_CNT_ACK_SLOT) begin
                  sh_q  <= new_byte;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == `TWS_CNT_LAST_BIT) begin
                     was_addr_q <= (st_q == `TWS_ST_ADDR);
                     if (st_q == `TWS_ST_ADDR) begin
                        match_q <= addr_hit;
                        dir_q   <= new_byte[0];
                        st_q    <= addr_hit ? `TWS_ST_DATA : `TWS_ST_OFF;
                     end
                  end
               end else if (cnt_q == `TWS_CNT_ACK_SLOT) begin
                  // transmitter reads ack; high means none
                  if (~was_addr_q & dir_q)
                     nack_q <= sda_s_q;
                  cnt_q <= `TWS_CNT_ACK_DONE;
               end
            end else if (scl_fall) begin
               if (cnt_q == `TWS_CNT_ACK_SLOT) begin
                  // receiver pulls ack low
                  so_q <= ~(was_addr_q | (st_q == `TWS_ST_DATA & ~dir_q));
               end else if (cnt_q == `TWS_CNT_ACK_DONE) begin
                  so_q      <= 1'b1;
                  cnt_q     <= `TWS_CNT_ZERO;
                  // hold clock low to prepare next byte
                  stretch_q <= (st_q == `TWS_ST_DATA) & ~nack_q;
               end else if (cnt_q != `TWS_CNT_ZERO) begin
                  so_q <= tx_data ? sh_q[7] : 1'b1;
               end else begin
                  so_q <= tx_data ? sh_q[7] : 1'b1;
               end
            end
         end
      end
   end

   // ---------------------------------------------
   // pins: open drain, pull low or release
   // ---------------------------------------------
   // high level comes only from the pull-ups, never from us
   assign scl_out = 1'b0;
   assign scl_oe  = stretch_q;
   assign sda_out = 1'b0;
   assign sda_oe  = channel_enable & ~so_q;

   // ---------------------------------------------
   // status outputs
   // ---------------------------------------------
   // everything below comes from flops or a plain state decode; clock_line_level is also gated by channel_enable
   assign serial_shift_register  = sh_q;
   assign transfer_done_irq_flag = done_q;
   assign address_match_flag     = match_q;
   assign slave_selected         = data_phase;
   assign direction_tx           = dir_q;
   assign nack_seen              = nack_q;
   assign start_seen             = start_q;
   assign stop_seen              = stop_q;
   assign transfer_busy          = armed_q | in_xfer;
   assign clock_line_level       = channel_enable & scl_s_q;

endmodule

// *** bench/tws_port_monitor.sv ***
module tws_port_monitor (
   // clock and controls
   input wire sys_clk,
   input wire reset,
   input wire channel_enable,
   input wire bus_mode,
   input wire shift_wr,
   input wire wait_release,
   input wire irq_clear,
   // status
   input wire transfer_done_irq_flag,
   input wire address_match_flag,
   input wire clock_line_level,
   input wire start_seen,
   input wire stop_seen,
   // pins
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // pin and flag checks
   // ----------------------------------------
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   pins_low_only_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   disabled_quiet_a: assert property (!channel_enable && !$past(channel_enable)
      |-> !sda_oe && !scl_oe && !address_match_flag && !clock_line_level)
      else $error("disabled port active");
   start_detect_a: assert property (bus_mode && channel_enable && scl_in &&
      $past(scl_in) && $fell(sda_in) |-> ##[1:6] start_seen) else $error("start missed");
   stop_detect_a: assert property (bus_mode && channel_enable && scl_in &&
      $past(scl_in) && $rose(sda_in) |-> ##[1:6] stop_seen) else $error("stop missed");
   done_sticky_a: assert property (transfer_done_irq_flag && !irq_clear && channel_enable
      |=> transfer_done_irq_flag) else $error("done flag lost");
   two_wire_drive_a: assert property (!bus_mode && channel_enable && $past(channel_enable)
      && $changed(sda_oe) |-> !$past(scl_in, 2)) else $error("data moved off clock low");
   stretch_hold_a: assert property (scl_oe && !shift_wr && !wait_release && channel_enable
      |=> scl_oe) else $error("wait dropped");
   stretch_low_a: assert property ($rose(scl_oe) |-> !scl_in) else $error("wait begun high");
   level_follow_a: assert property ((channel_enable && scl_in) [*5] |-> clock_line_level)
      else $error("clock level stale");
   cover property (start_seen);
   cover property ($rose(scl_oe));
   cover property (bus_mode && $rose(transfer_done_irq_flag));
endmodule

bind tws_port tws_port_monitor mon (.sys_clk, .reset, .channel_enable, .bus_mode, .shift_wr,
   .wait_release, .irq_clear, .transfer_done_irq_flag, .address_match_flag,
   .clock_line_level, .start_seen, .stop_seen, .scl_in, .scl_out, .scl_oe, .sda_in,
   .sda_out, .sda_oe);

// *** bench/tws_master.sv ***
module tws_master (
   // bus wires
   input  wire logic scl_w,
   input  wire logic sda_w,
   // pulls, 1 = released
   output logic      scl_m,
   output logic      sda_m
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // one clock, data set while low, waits out a stretch
   task automatic cyc(input logic b, output logic r);
      int n;
      scl_m = 1'b0;
      #100 sda_m = b;
      #300 scl_m = 1'b1;
      for (n = 0; n < 300 && !scl_w; n++) #100;
      #400 r = sda_w;
   endtask
   // start when s is 1, stop when s is 0
   task automatic cond(input logic s);
      logic r;
      cyc(s, r);
      sda_m = !s;
      #400 scl_m = !s;
   endtask
   // eight bits msb first, then the ack slot
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) cyc(d[i], q[i]);
      cyc(ak, a);
      scl_m = 1'b0;
   endtask
endmodule

// *** bench/test_tws_port.sv ***
`include "tws_defs.vh"
module test_tws_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic       channel_enable = 1'b0;
   logic       bus_mode = 1'b0;
   logic       wakeup_select = 1'b0;
   logic [7:0] slave_address_register = 8'h00;
   logic       shift_wr = 1'b0;
   logic [7:0] shift_wdata = 8'h00;
   logic       wait_release = 1'b0;
   logic       irq_clear = 1'b0;
   logic [7:0] lfsr = 8'h3C;
   int         err_total = 0;
   int         samples_checked = 0;
   wire        transfer_done_irq_flag, address_match_flag, slave_selected, direction_tx;
   wire        nack_seen, transfer_busy, scl_oe, sda_oe, scl_m, sda_m;
   wire [7:0]  serial_shift_register;
   wire        scl_w = scl_m & ~scl_oe; // pull-up when all release
   wire        sda_w = sda_m & ~sda_oe;
   tws_port dut (.sys_clk, .reset, .channel_enable, .bus_mode, .wakeup_select,
      .slave_address_register, .shift_wr, .shift_wdata, .serial_shift_register,
      .wait_release, .irq_clear, .transfer_done_irq_flag, .address_match_flag,
      .slave_selected, .direction_tx, .nack_seen, .start_seen(), .stop_seen(),
      .transfer_busy, .clock_line_level(), .scl_in(scl_w), .scl_out(), .scl_oe,
      .sda_in(sda_w), .sda_out(), .sda_oe);
   tws_master far (.scl_w, .sda_w, .scl_m, .sda_m);
   always #50 sys_clk = ~sys_clk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   // line level when the far side pulls the bits of m low
   function automatic logic [7:0] on_wire(input logic [7:0] d, m);
      return d & ~m;
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk) s = 1'b1;
      @(negedge sys_clk) s = 1'b0;
   endtask
   // let the ninth fall land, then look at the wait
   task automatic stall(input logic e);
      repeat (8) @(negedge sys_clk);
      chk("wait", scl_oe, e);
   endtask
   task automatic complete_run();
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      err_total++;
      complete_run();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d, m, q;
      logic       a;
      logic [7:0] ad [3];
      ad = '{8'hA4, 8'hA5, 8'h26};
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      chk("reset shift", serial_shift_register, `TWS_SHIFT_RST);
      shift_wdata = 8'h5A;
      pulse(shift_wr);
      channel_enable = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("late enable", transfer_busy, 1'b0);
      // two-wire: receive after FF, clean and corrupted sends
      for (int k = 0; k < 8; k++) begin
         d = k[0] ? rnd() : 8'hFF;
         m = k[1] ? 8'h00 : rnd();
         slave_address_register = d;
         shift_wdata = d;
         pulse(shift_wr);
         for (int i = 7; i >= 0; i--) far.cyc(~m[i], q[i]);
         repeat (6) @(negedge sys_clk);
         chk("wire bits", q, on_wire(d, m));
         chk("captured", serial_shift_register, on_wire(d, m));
         chk("done", transfer_done_irq_flag, 1'b1);
         chk("match", address_match_flag, on_wire(d, m) == d);
         pulse(irq_clear);
      end
      // bus mode slave with wakeup: write, read, foreign address
      channel_enable = 1'b0;
      bus_mode = 1'b1;
      wakeup_select = 1'b1;
      slave_address_register = 8'hA4;
      @(negedge sys_clk) channel_enable = 1'b1;
      for (int j = 0; j < 3; j++) begin
         pulse(irq_clear);
         far.cond(1'b1);
         far.xfer(ad[j], 1'b1, q, a);
         stall(j != 2);
         chk("addr ack", a, j == 2);
         chk("wakeup irq", transfer_done_irq_flag, j != 2);
         chk("selected", slave_selected, j != 2);
         chk("direction", direction_tx, j == 1);
         d = rnd();
         if (j == 1) begin
            shift_wdata = d;
            pulse(shift_wr);
            far.xfer(8'hFF, 1'b1, q, a);
            stall(1'b0);
            chk("read data", q, d);
            chk("nack", nack_seen, 1'b1);
         end else if (j == 0) begin
            pulse(wait_release);
            far.xfer(d, 1'b1, q, a);
            stall(1'b1);
            chk("data ack", a, 1'b0);
            chk("rx data", serial_shift_register, d);
            pulse(wait_release);
         end
         pulse(irq_clear);
         far.cond(1'b0);
         repeat (8) @(negedge sys_clk);
         chk("stop irq", transfer_done_irq_flag, 1'b1);
         chk("released", slave_selected, 1'b0);
      end
      complete_run();
   end
endmodule
